// ===== rtl/dsd_decoder.sv
// data space decoder: region decode, io translation, pointer update, stalls
// assumes the core holds its request while stall is high
`timescale 1ns/1ps
// Operation
// - the low 4352 addresses are 32 registers, 64 io, 160 extended io, then 4096 sram bytes.
// - io instructions use 0x00-0x3F and the same registers sit 0x20 higher in data space.
// - extended io 0x60-0xFF is reachable only by load and store, never by io in or out.
// - single-bit set, clear and skip work only on io addresses 0x00-0x1F.
// - single-bit set and clear change only the addressed bit, sparing write-one-to-clear flags.
// - some status flags clear when a one is written and hold when a zero is written.
// - every internal sram access takes two clock cycles.
// - an eeprom read stalls the core for four cycles.
// - an eeprom write stalls the core for two cycles.
// - the eeprom is its own 2K byte space read and written one byte at a time.
// - eeprom writes are self-timed and expose a busy indication software can poll.
// - a reset during an eeprom write lets the write finish.
// - displacement addressing uses the Y or Z pointer plus up to 63.
// - pre-decrement lowers the pointer before use, post-increment raises it after, for X, Y and Z.
// - direct addressing reaches every data space location.
// - the program counter is 15 bits and addresses 16-bit program words.
module dsd_decoder (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        req_valid,
    input  wire logic [3:0]  req_op,
    input  wire logic [2:0]  req_amode,
    input  wire logic [1:0]  req_ptr,
    input  wire logic [15:0] req_addr,
    input  wire logic [5:0]  req_disp,
    input  wire logic [2:0]  req_bit,
    input  wire logic [15:0] ptr_x,
    input  wire logic [15:0] ptr_y,
    input  wire logic [15:0] ptr_z,
    input  wire logic [7:0]  io_rdata,
    input  wire logic [7:0]  io_w1c_mask,
    input  wire logic        ee_read_start,
    input  wire logic        ee_write_start,
    input  wire logic [10:0] ee_addr,
    input  wire logic [7:0]  ee_wdata,
    input  wire logic [14:0] pc_next,
    input  wire logic        pc_load,
    output logic      [15:0] mem_addr,
    output logic      [2:0]  mem_region,
    output logic             mem_illegal,
    output logic      [7:0]  io_bit_wdata,
    output logic             io_bit_we,
    output logic             skip_taken,
    output logic      [15:0] ptr_new,
    output logic             ptr_we,
    output logic      [1:0]  ptr_sel,
    output logic             stall,
    output logic             ee_busy,
    output logic      [7:0]  ee_rdata,
    output logic      [14:0] program_counter
);
    localparam int EE_DEPTH = 2048;

    typedef struct packed {
        dsd_pkg::dsd_state_t st;
        logic [2:0]  cnt;
        logic [15:0] ee_tmr;
        logic        ee_busy;
        logic [10:0] ee_waddr;
        logic [7:0]  ee_wbyte;
        logic [15:0] addr;
        logic [2:0]  region;
        logic        illegal;
        logic [7:0]  bit_wdata;
        logic        bit_we;
        logic        skip;
        logic [15:0] ptr_new;
        logic        ptr_we;
        logic [1:0]  ptr_sel;
        logic        stall;
        logic [7:0]  ee_rdata;
        logic [14:0] pc;
    } dsd_state_s_t;

    // power-up value: the eeprom write fields never see reset
    dsd_state_s_t s_reg = '0;
    dsd_state_s_t s_next;

    // eeprom array: contents survive reset, not a control register
    logic [7:0] ee_mem [EE_DEPTH];

    logic [15:0] base;
    logic [15:0] eff;
    logic        is_io_op;
    logic        is_bit_op;
    logic [7:0]  bit_new;
    logic        bit_val;
    logic        ee_wr_done;

    dsd_bitop u_bitop (
        .cur_val   (io_rdata),
        .bit_sel   (req_bit),
        .set_bit   (req_op == dsd_pkg::DSD_OP_SBI),
        .w1c_mask  (io_w1c_mask),
        .new_val   (bit_new),
        .bit_mask  (),
        .bit_value (bit_val)
    );

    assign ee_wr_done = s_reg.ee_busy && (s_reg.ee_tmr == 16'h0000);

    always_comb begin
        s_next           = s_reg;
        s_next.bit_we    = 1'b0;
        s_next.ptr_we    = 1'b0;
        s_next.skip      = 1'b0;
        base             = ptr_x;
        eff              = req_addr;
        is_io_op         = (req_op == dsd_pkg::DSD_OP_IN) || (req_op == dsd_pkg::DSD_OP_OUT);
        is_bit_op        = (req_op >= dsd_pkg::DSD_OP_SBI) && (req_op <= dsd_pkg::DSD_OP_SKC);

        if (pc_load) begin
            s_next.pc = pc_next;
        end

        if (s_reg.ee_busy) begin
            s_next.ee_tmr = s_reg.ee_tmr - 16'h0001;
            if (ee_wr_done) begin
                s_next.ee_busy = 1'b0;
            end
        end

        case (req_ptr)
            dsd_pkg::DSD_PTR_Y: base = ptr_y;
            dsd_pkg::DSD_PTR_Z: base = ptr_z;
            default:            base = ptr_x;
        endcase

        case (s_reg.st)
            dsd_pkg::DSD_ST_IDLE: begin
                s_next.stall = 1'b0;
                if (ee_read_start) begin
                    s_next.ee_rdata = ee_mem[ee_addr];
                    // count equals the stall cycles here, sram counts one less
                    s_next.cnt      = dsd_pkg::DSD_EERD_STALL;
                    s_next.stall    = 1'b1;
                    s_next.st       = dsd_pkg::DSD_ST_EERD;
                end else if (ee_write_start && !s_reg.ee_busy) begin
                    s_next.ee_busy  = 1'b1;
                    s_next.ee_tmr   = dsd_pkg::DSD_EEWR_TIME;
                    s_next.ee_waddr = ee_addr;
                    s_next.ee_wbyte = ee_wdata;
                    // full count: the stall drops as the count leaves one
                    s_next.cnt      = dsd_pkg::DSD_EEWR_STALL;
                    s_next.stall    = 1'b1;
                    s_next.st       = dsd_pkg::DSD_ST_EEWR;
                end else if (req_valid && req_op != dsd_pkg::DSD_OP_NONE) begin
                    if (is_io_op || is_bit_op) begin
                        eff = {10'h000, req_addr[5:0]} + dsd_pkg::DSD_IO_OFFSET;
                    end else begin
                        case (req_amode)
                            // Y or Z plus up to 63
                            dsd_pkg::DSD_AM_DISP:   eff = base + {10'h000, req_disp};
                            dsd_pkg::DSD_AM_PREDEC: eff = base - 16'h0001;
                            dsd_pkg::DSD_AM_IND,
                            dsd_pkg::DSD_AM_POSTIN: eff = base;
                            default:                eff = req_addr;
                        endcase
                        if (req_amode == dsd_pkg::DSD_AM_PREDEC) begin
                            s_next.ptr_new = base - 16'h0001;
                            s_next.ptr_we  = 1'b1;
                        end else if (req_amode == dsd_pkg::DSD_AM_POSTIN) begin
                            s_next.ptr_new = base + 16'h0001;
                            s_next.ptr_we  = 1'b1;
                        end
                        s_next.ptr_sel = req_ptr;
                    end
                    s_next.addr = eff;
                    if (eff < dsd_pkg::DSD_IO_BASE) begin
                        s_next.region = dsd_pkg::DSD_RG_REGF;
                    end else if (eff < dsd_pkg::DSD_EXT_BASE) begin
                        s_next.region = dsd_pkg::DSD_RG_IO;
                    end else if (eff < dsd_pkg::DSD_SRAM_BASE) begin
                        s_next.region = dsd_pkg::DSD_RG_EXT;
                    end else if (eff < dsd_pkg::DSD_SRAM_END) begin
                        s_next.region = dsd_pkg::DSD_RG_SRAM;
                    end else begin
                        s_next.region = dsd_pkg::DSD_RG_NONE;
                    end
                    s_next.illegal = 1'b0;
                    if (is_io_op && req_addr[15:6] != 10'h000) begin
                        s_next.illegal = 1'b1;
                    end
                    // displacement only on Y or Z
                    if (req_amode == dsd_pkg::DSD_AM_DISP && req_ptr == dsd_pkg::DSD_PTR_X
                        && !is_io_op && !is_bit_op) begin
                        s_next.illegal = 1'b1;
                    end
                    // bit ops limited to low io
                    if (is_bit_op) begin
                        if (req_addr[15:0] > {10'h000, dsd_pkg::DSD_BIT_MAX}) begin
                            s_next.illegal = 1'b1;
                        end else if (req_op == dsd_pkg::DSD_OP_SBI || req_op == dsd_pkg::DSD_OP_CBI) begin
                            s_next.bit_wdata = bit_new;
                            s_next.bit_we    = 1'b1;
                        end else begin
                            s_next.skip = (req_op == dsd_pkg::DSD_OP_SKS) ? bit_val : !bit_val;
                        end
                    end
                    if (s_next.region == dsd_pkg::DSD_RG_SRAM && !is_io_op && !is_bit_op) begin
                        s_next.cnt   = dsd_pkg::DSD_SRAM_CYC - 3'h1;
                        s_next.stall = 1'b1;
                        s_next.st    = dsd_pkg::DSD_ST_SRAM;
                    end
                end
            end
            dsd_pkg::DSD_ST_SRAM,
            dsd_pkg::DSD_ST_EERD,
            dsd_pkg::DSD_ST_EEWR: begin
                s_next.cnt   = s_reg.cnt - 3'h1;
                s_next.stall = (s_reg.cnt > 3'h1);
                if (s_reg.cnt == 3'h1) begin
                    s_next.st = dsd_pkg::DSD_ST_IDLE;
                end
            end
            default: begin
                s_next.st    = dsd_pkg::DSD_ST_IDLE;
                s_next.stall = 1'b0;
            end
        endcase
    end

    // eeprom write fields skip reset, pause while it is held
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.st        <= dsd_pkg::DSD_ST_IDLE;
            s_reg.cnt       <= 3'h0;
            s_reg.addr      <= 16'h0000;
            s_reg.region    <= dsd_pkg::DSD_RG_REGF;
            s_reg.illegal   <= 1'b0;
            s_reg.bit_wdata <= 8'h00;
            s_reg.bit_we    <= 1'b0;
            s_reg.skip      <= 1'b0;
            s_reg.ptr_new   <= 16'h0000;
            s_reg.ptr_we    <= 1'b0;
            s_reg.ptr_sel   <= 2'h0;
            s_reg.stall     <= 1'b0;
            s_reg.ee_rdata  <= 8'h00;
            s_reg.pc        <= 15'h0000;
        end else begin
            s_reg.st        <= s_next.st;
            s_reg.cnt       <= s_next.cnt;
            s_reg.addr      <= s_next.addr;
            s_reg.region    <= s_next.region;
            s_reg.illegal   <= s_next.illegal;
            s_reg.bit_wdata <= s_next.bit_wdata;
            s_reg.bit_we    <= s_next.bit_we;
            s_reg.skip      <= s_next.skip;
            s_reg.ptr_new   <= s_next.ptr_new;
            s_reg.ptr_we    <= s_next.ptr_we;
            s_reg.ptr_sel   <= s_next.ptr_sel;
            s_reg.stall     <= s_next.stall;
            s_reg.ee_rdata  <= s_next.ee_rdata;
            s_reg.pc        <= s_next.pc;
            s_reg.ee_tmr    <= s_next.ee_tmr;
            s_reg.ee_busy   <= s_next.ee_busy;
            s_reg.ee_waddr  <= s_next.ee_waddr;
            s_reg.ee_wbyte  <= s_next.ee_wbyte;
        end
    end

    // no reset here: a write in flight still lands
    always_ff @(posedge clk_sys) begin
        if (ee_wr_done) begin
            ee_mem[s_reg.ee_waddr] <= s_reg.ee_wbyte;
        end
    end

    assign mem_addr        = s_reg.addr;
    assign mem_region      = s_reg.region;
    assign mem_illegal     = s_reg.illegal;
    assign io_bit_wdata    = s_reg.bit_wdata;
    assign io_bit_we       = s_reg.bit_we;
    assign skip_taken      = s_reg.skip;
    assign ptr_new         = s_reg.ptr_new;
    assign ptr_we          = s_reg.ptr_we;
    assign ptr_sel         = s_reg.ptr_sel;
    assign stall           = s_reg.stall;
    assign ee_busy         = s_reg.ee_busy;
    assign ee_rdata        = s_reg.ee_rdata;
    assign program_counter = s_reg.pc;

    sram_two_cyc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == dsd_pkg::DSD_ST_IDLE && s_next.st == dsd_pkg::DSD_ST_SRAM |=> stall ##1 !stall)
        else $error("sram access not two cycles");
    ee_rd_stall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == dsd_pkg::DSD_ST_IDLE && s_next.st == dsd_pkg::DSD_ST_EERD |=> stall[*4] ##1 !stall)
        else $error("eeprom read stall not four cycles");
    ee_wr_stall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == dsd_pkg::DSD_ST_IDLE && s_next.st == dsd_pkg::DSD_ST_EEWR |=> stall[*2] ##1 !stall)
        else $error("eeprom write stall not two cycles");
    bit_range_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_bit_we |-> mem_addr < (dsd_pkg::DSD_IO_OFFSET + 16'h0020))
        else $error("bit op outside low io");
    io_offset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == dsd_pkg::DSD_ST_IDLE && req_valid && !ee_read_start && !ee_write_start
        && req_op == dsd_pkg::DSD_OP_IN |=> mem_addr == $past(req_addr[5:0]) + 16'h0020)
        else $error("io address not offset by 0x20");
    // extended io not by io out
    ext_io_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == dsd_pkg::DSD_ST_IDLE && req_valid && !ee_read_start && !ee_write_start
        && req_op == dsd_pkg::DSD_OP_OUT |=> mem_region != dsd_pkg::DSD_RG_EXT)
        else $error("io out reached extended io");
    sram_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mem_region == dsd_pkg::DSD_RG_SRAM |-> mem_addr >= 16'h0100 && mem_addr < 16'h1100)
        else $error("sram region decode wrong");
    post_inc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ptr_we && mem_addr != ptr_new |-> ptr_new == mem_addr + 16'h0001 || ptr_new == mem_addr)
        else $error("pointer update wrong");
    ee_busy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(ee_busy) |-> ee_busy[*8])
        else $error("eeprom busy dropped early");

    sram_cov_c: cover property (@(posedge clk_sys) disable iff (!reset_n) s_reg.st == dsd_pkg::DSD_ST_SRAM);
    eerd_cov_c: cover property (@(posedge clk_sys) disable iff (!reset_n) s_reg.st == dsd_pkg::DSD_ST_EERD);
    eewr_cov_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(ee_busy));
    skip_cov_c: cover property (@(posedge clk_sys) disable iff (!reset_n) skip_taken);
endmodule

// ===== rtl/dsd_pkg.sv
// package for the data space decoder: map, instruction kinds, stall counts
// assumes a core that issues one data access request at a time
package dsd_pkg;
    localparam int          DSD_AW         = 16;
    localparam int          DSD_PCW        = 15;
    localparam int          DSD_EEAW       = 11;
    localparam logic [15:0] DSD_REG_BASE   = 16'h0000;
    localparam logic [15:0] DSD_IO_BASE    = 16'h0020;
    localparam logic [15:0] DSD_EXT_BASE   = 16'h0060;
    localparam logic [15:0] DSD_SRAM_BASE  = 16'h0100;
    localparam logic [15:0] DSD_SRAM_END   = 16'h1100;
    localparam logic [15:0] DSD_IO_OFFSET  = 16'h0020;
    localparam logic [5:0]  DSD_IO_MAX     = 6'h3F;
    localparam logic [5:0]  DSD_BIT_MAX    = 6'h1F;
    localparam logic [5:0]  DSD_DISP_MAX   = 6'h3F;
    localparam logic [2:0]  DSD_SRAM_CYC   = 3'h2;
    localparam logic [2:0]  DSD_EERD_STALL = 3'h4;
    localparam logic [2:0]  DSD_EEWR_STALL = 3'h2;
    localparam logic [15:0] DSD_EEWR_TIME  = 16'h0100;

    // instruction kinds presented by the core
    localparam logic [3:0] DSD_OP_NONE  = 4'h0;
    localparam logic [3:0] DSD_OP_LOAD  = 4'h1;
    localparam logic [3:0] DSD_OP_STORE = 4'h2;
    localparam logic [3:0] DSD_OP_IN    = 4'h3;
    localparam logic [3:0] DSD_OP_OUT   = 4'h4;
    localparam logic [3:0] DSD_OP_SBI   = 4'h5;
    localparam logic [3:0] DSD_OP_CBI   = 4'h6;
    localparam logic [3:0] DSD_OP_SKS   = 4'h7;
    localparam logic [3:0] DSD_OP_SKC   = 4'h8;

    // addressing modes
    localparam logic [2:0] DSD_AM_DIRECT = 3'h0;
    localparam logic [2:0] DSD_AM_IND    = 3'h1;
    localparam logic [2:0] DSD_AM_DISP   = 3'h2;
    localparam logic [2:0] DSD_AM_PREDEC = 3'h3;
    localparam logic [2:0] DSD_AM_POSTIN = 3'h4;

    // pointer select
    localparam logic [1:0] DSD_PTR_X = 2'h0;
    localparam logic [1:0] DSD_PTR_Y = 2'h1;
    localparam logic [1:0] DSD_PTR_Z = 2'h2;

    // region codes
    localparam logic [2:0] DSD_RG_REGF = 3'h0;
    localparam logic [2:0] DSD_RG_IO   = 3'h1;
    localparam logic [2:0] DSD_RG_EXT  = 3'h2;
    localparam logic [2:0] DSD_RG_SRAM = 3'h3;
    localparam logic [2:0] DSD_RG_NONE = 3'h4;

    typedef enum logic [3:0] {
        DSD_ST_IDLE  = 4'b0001,
        DSD_ST_SRAM  = 4'b0010,
        DSD_ST_EERD  = 4'b0100,
        DSD_ST_EEWR  = 4'b1000
    } dsd_state_t;
endpackage

// ===== rtl/dsd_bitop.sv
// single-bit modify and test of one io register byte
// assumes the caller gives the current register value and bit index
`timescale 1ns/1ps
module dsd_bitop (
    input  wire logic [7:0] cur_val,
    input  wire logic [2:0] bit_sel,
    input  wire logic       set_bit,
    input  wire logic [7:0] w1c_mask,
    output logic      [7:0] new_val,
    output logic      [7:0] bit_mask,
    output logic            bit_value
);
    always_comb begin
        bit_mask  = 8'h01 << bit_sel;
        bit_value = |(cur_val & bit_mask);
        // only the addressed bit
        // w1c flags elsewhere see a zero written, so they stay put
        new_val   = set_bit ? (cur_val | bit_mask) : (cur_val & ~bit_mask);
        new_val   = (new_val & ~w1c_mask) | (w1c_mask & bit_mask & {8{set_bit}});
    end
endmodule

// ===== bench/dsd_core_model.sv
// core-side model: issues one data access request at a time
// assumes the bench waits for stall low before each request
`timescale 1ns/1ps
module dsd_core_model (
    input  wire logic        clk_sys,
    output logic             req_valid,
    output logic      [3:0]  req_op,
    output logic      [2:0]  req_amode,
    output logic      [1:0]  req_ptr,
    output logic      [15:0] req_addr,
    output logic      [5:0]  req_disp,
    output logic      [2:0]  req_bit
);
    initial begin
        req_valid = 1'b0;
        req_op    = dsd_pkg::DSD_OP_NONE;
        req_amode = dsd_pkg::DSD_AM_DIRECT;
        req_ptr   = dsd_pkg::DSD_PTR_X;
        req_addr  = 16'h0000;
        req_disp  = 6'h00;
        req_bit   = 3'h0;
    end

    // no reserved writes
    // released address, displacement and bit fields go inverse so stale values never look valid
    task automatic issue(input logic [3:0] op, input logic [2:0] am, input logic [1:0] ps,
                         input logic [15:0] a, input logic [5:0] d, input logic [2:0] b);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_op    <= op;
        req_amode <= am;
        req_ptr   <= ps;
        req_addr  <= a;
        req_disp  <= d;
        req_bit   <= b;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req_op    <= dsd_pkg::DSD_OP_NONE;
        req_addr  <= ~a;
        req_disp  <= ~d;
        req_bit   <= ~b;
    endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the data space decoder
// assumes registered outputs one cycle after the taking edge
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, reset_n, req_valid, ee_read_start, ee_write_start, pc_load;
    logic [3:0]  req_op;
    logic [2:0]  req_amode, req_bit, mem_region;
    logic [1:0]  req_ptr, ptr_sel;
    logic [15:0] req_addr, ptr_x, ptr_y, ptr_z, mem_addr, ptr_new;
    logic [5:0]  req_disp;
    logic [7:0]  io_rdata, io_w1c_mask, ee_wdata, io_bit_wdata, ee_rdata, r, w, m, d;
    logic [10:0] ee_addr;
    logic [14:0] pc_next, program_counter;
    logic        mem_illegal, io_bit_we, skip_taken, ptr_we, stall, ee_busy;
    logic [15:0] a;
    logic [15:0] bounds [9] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060,
                                16'h00FF, 16'h0100, 16'h10FF, 16'h1100};
    logic [7:0]  ee_q [$];
    int          errors, n_checks, seed, st_cnt, i;

    dsd_decoder dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid), .req_op(req_op),
        .req_amode(req_amode), .req_ptr(req_ptr), .req_addr(req_addr), .req_disp(req_disp),
        .req_bit(req_bit), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z), .io_rdata(io_rdata),
        .io_w1c_mask(io_w1c_mask), .ee_read_start(ee_read_start), .ee_write_start(ee_write_start),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .pc_next(pc_next), .pc_load(pc_load),
        .mem_addr(mem_addr), .mem_region(mem_region), .mem_illegal(mem_illegal),
        .io_bit_wdata(io_bit_wdata), .io_bit_we(io_bit_we), .skip_taken(skip_taken),
        .ptr_new(ptr_new), .ptr_we(ptr_we), .ptr_sel(ptr_sel), .stall(stall), .ee_busy(ee_busy),
        .ee_rdata(ee_rdata), .program_counter(program_counter));

    dsd_core_model core_u (.clk_sys(clk_sys), .req_valid(req_valid), .req_op(req_op),
        .req_amode(req_amode), .req_ptr(req_ptr), .req_addr(req_addr), .req_disp(req_disp),
        .req_bit(req_bit));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [2:0] exp_region(input int x);
        if (x < 32) return dsd_pkg::DSD_RG_REGF;
        if (x < 96) return dsd_pkg::DSD_RG_IO;
        if (x < 256) return dsd_pkg::DSD_RG_EXT;
        if (x < 4352) return dsd_pkg::DSD_RG_SRAM;
        return dsd_pkg::DSD_RG_NONE;
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [3:0] op, input logic [2:0] am, input logic [1:0] ps,
                       input logic [15:0] x, input logic [5:0] dd, input logic [2:0] b);
        core_u.issue(op, am, ps, x, dd, b);
        @(negedge clk_sys);
    endtask

    // bounded wait: stall cycles counted from the first answer cycle
    task automatic count_stall();
        st_cnt = 0;
        while (stall !== 1'b0) begin
            st_cnt++;
            if (st_cnt > 20) begin
                errors++;
                conclude();
            end
            @(negedge clk_sys);
        end
    endtask

    task automatic ee_op(input logic wr, input logic [10:0] ea, input logic [7:0] ed);
        @(posedge clk_sys);
        ee_write_start <= wr;
        ee_read_start  <= ~wr;
        ee_addr        <= ea;
        ee_wdata       <= ed;
        @(posedge clk_sys);
        ee_write_start <= 1'b0;
        ee_read_start  <= 1'b0;
        ee_addr        <= ~ea;
        ee_wdata       <= ~ed;
        @(negedge clk_sys);
    endtask

    task automatic wait_ee();
        int n;
        n = 0;
        while (ee_busy !== 1'b0) begin
            n++;
            if (n > 400) begin
                errors++;
                conclude();
            end
            @(negedge clk_sys);
        end
    endtask

    initial begin
        seed = 33; errors = 0; n_checks = 0; reset_n = 1'b0;
        ptr_x = 16'h0180; ptr_y = 16'h0A00; ptr_z = 16'h10FF; io_rdata = 8'h00; io_w1c_mask = 8'h00;
        ee_read_start = 1'b0; ee_write_start = 1'b0; ee_addr = 11'h000; ee_wdata = 8'h00;
        pc_next = 15'h0000; pc_load = 1'b0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (i = 0; i < 20; i++) begin
            a = (i < 9) ? bounds[i] : 16'($random(seed)) & 16'h1FFF;
            run(i[0] ? dsd_pkg::DSD_OP_STORE : dsd_pkg::DSD_OP_LOAD, dsd_pkg::DSD_AM_DIRECT, 2'h0, a, 6'h00, 3'h0);
            check(mem_addr, a);
            check(16'(mem_region), 16'(exp_region(int'(a))));
            count_stall();
            check(16'(st_cnt), (exp_region(int'(a)) == dsd_pkg::DSD_RG_SRAM) ? 16'h0001 : 16'h0000);
        end
        $display("region map test done");
        for (i = 0; i < 8; i++) begin
            a = (i < 2) ? 16'h0000 : (i < 4) ? 16'h003F : 16'($random(seed)) & 16'h003F;
            run(i[0] ? dsd_pkg::DSD_OP_OUT : dsd_pkg::DSD_OP_IN, dsd_pkg::DSD_AM_DIRECT, 2'h0, a, 6'h00, 3'h0);
            check(mem_addr, a + 16'h0020);
            check(16'({mem_illegal, mem_region}), 16'(dsd_pkg::DSD_RG_IO));
        end
        run(dsd_pkg::DSD_OP_IN, dsd_pkg::DSD_AM_DIRECT, 2'h0, 16'h0040, 6'h00, 3'h0);
        check(16'(mem_illegal), 16'h0001);
        $display("io translation test done");
        for (i = 0; i < 17; i++) begin
            r = 8'($random(seed)); w = 8'($random(seed)); a = 16'($random(seed)) & 16'h001F;
            if (i == 16) a = 16'h0020;
            m = 8'h01 << i[4:2];
            @(posedge clk_sys);
            io_rdata <= r;
            io_w1c_mask <= w;
            run(dsd_pkg::DSD_OP_SBI + 4'(i % 4), dsd_pkg::DSD_AM_DIRECT, 2'h0, a, 6'h00, i[4:2]);
            check(16'(mem_illegal), (i == 16) ? 16'h0001 : 16'h0000);
            check(16'(io_bit_we), (i % 4 < 2 && i < 16) ? 16'h0001 : 16'h0000);
            if (i % 4 < 2 && i < 16)
                check(16'(io_bit_wdata), 16'(((i % 4 == 0) ? (r | m) : (r & ~m)) & ~(w & ~m)));
            if (i % 4 > 1 && i < 16)
                check(16'(skip_taken), 16'(((r & m) != 8'h00) ^ (i % 4 == 3)));
        end
        $display("bit op test done");
        run(dsd_pkg::DSD_OP_LOAD, dsd_pkg::DSD_AM_PREDEC, dsd_pkg::DSD_PTR_X, 16'h0000, 6'h00, 3'h0);
        check(mem_addr, 16'h017F);
        check({ptr_new[14:0], ptr_we}, {15'h017F, 1'b1});
        count_stall();
        run(dsd_pkg::DSD_OP_STORE, dsd_pkg::DSD_AM_POSTIN, dsd_pkg::DSD_PTR_Z, 16'h0000, 6'h00, 3'h0);
        check(mem_addr, 16'h10FF);
        check(ptr_new, 16'h1100);
        check(16'({ptr_we, ptr_sel}), 16'h0006);
        count_stall();
        run(dsd_pkg::DSD_OP_LOAD, dsd_pkg::DSD_AM_DISP, dsd_pkg::DSD_PTR_Y, 16'h0000, 6'h3F, 3'h0);
        check(mem_addr, 16'h0A3F);
        count_stall();
        run(dsd_pkg::DSD_OP_LOAD, dsd_pkg::DSD_AM_DISP, dsd_pkg::DSD_PTR_X, 16'h0000, 6'h01, 3'h0);
        check(16'(mem_illegal), 16'h0001);
        count_stall();
        $display("pointer test done");
        d = 8'($random(seed));
        ee_op(1'b1, 11'h7FF, d);
        ee_q.push_back(d);
        check(16'(ee_busy), 16'h0001);
        count_stall();
        check(16'(st_cnt), 16'h0002);
        ee_op(1'b1, 11'h7FF, ~d);
        check(16'(stall), 16'h0000);
        wait_ee();
        ee_op(1'b0, 11'h7FF, 8'h00);
        check(16'(ee_rdata), {8'h00, ee_q.pop_front()});
        count_stall();
        check(16'(st_cnt), 16'h0004);
        ee_op(1'b1, 11'h001, ~d);
        ee_q.push_back(~d);
        count_stall();
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        check(16'(ee_busy), 16'h0001);
        wait_ee();
        ee_op(1'b0, 11'h001, 8'h00);
        check(16'(ee_rdata), {8'h00, ee_q.pop_front()});
        count_stall();
        $display("eeprom test done");
        for (i = 0; i < 3; i++) begin
            a = (i == 0) ? 16'h7FFF : 16'($random(seed));
            @(posedge clk_sys);
            pc_next <= a[14:0];
            pc_load <= 1'b1;
            @(posedge clk_sys);
            pc_load <= 1'b0;
            @(negedge clk_sys);
            check(16'(program_counter), {1'b0, a[14:0]});
        end
        $display("program counter test done");
        conclude();
    end
endmodule
